// ---- rtl/jtp_tap.sv ----
`timescale 1ns/1ns
// Operation
// [RULE1] Next state from state and sampled mode-select
// [RULE2] Test reset low forces and holds reset
// [RULE3] Entering reset state loads IDCODE instruction
// [RULE4] Five high mode-select clocks reach reset
// [RULE5] Power-on reset also resets the TAP
// [RULE6] Stopped test clock keeps state and chains
// [RULE7] Serial input sampled rising, routed to chain
// [RULE8] Tester changes inputs on falling edge
// [RULE9] Serial output changes on falling edge
// [RULE10] Output idle unless actively shifting out
// [RULE11] Unimplemented instruction codes act as BYPASS
// [RULE12] EXTEST/INTEST leave all chains untouched
// [RULE13] Held instruction selects the data chain
// [RULE14] State picks chain and capture/shift/update
// [RULE15] Capture loads, shift moves one bit
// [RULE16] Update copies chain into held register; the user chain skips the copy while busy
// [RULE17] Instruction chain and register four bits
// [RULE18] Output muxed with embedded second controller
// [RULE19] Full sixteen-state standard transition graph
module jtp_tap
  import jtp_pkg::*;
#(
  parameter logic [`JTP_ID_W-1:0] ID_VALUE = `JTP_ID_RST // Arbitrary value
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  tck,
  input  wire logic                  trst_n,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdo_oe,
  input  wire logic                  aux_tdo,
  output logic                       aux_sel,
  input  wire logic [`JTP_BND_W-1:0] bnd_in,
  output logic      [`JTP_BND_W-1:0] bnd_out,
  output logic                       bnd_drive,
  output logic                       word_valid,
  output jtp_word_t                  word_data,
  input  wire logic                  word_ready
);
  // TAP reset: test reset pin or chip power-on reset
  logic tap_rst_n;
  assign tap_rst_n = trst_n & nrst; // [RULE2] [RULE5]

  jtp_state_t                state_reg;     // TAP state
  jtp_state_t                state_next;    // Next TAP state
  logic [`JTP_IR_W-1:0]      ir_shift_reg;  // Instruction chain
  logic [`JTP_IR_W-1:0]      ir_reg;        // Held instruction
  logic [`JTP_IR_W-1:0]      ir_eff;        // Decoded instruction
  logic                      byp_reg;       // Bypass chain
  logic [`JTP_ID_W-1:0]      id_shift_reg;  // Identity chain
  logic [`JTP_BND_W-1:0]     bnd_shift_reg; // Boundary chain
  logic [`JTP_BND_W-1:0]     bnd_upd_reg;   // Boundary held value
  logic [`JTP_BND_W-1:0]     bnd_smp_reg;   // Settled pin sample
  logic [`JTP_USR_W-1:0]     usr_shift_reg; // User word chain
  logic [`JTP_USR_W-1:0]     usr_word_reg;  // User held word
  logic                      req_tgl_reg;   // Word request toggle
  logic                      ack_seen_reg;  // Settled ack toggle
  logic                      busy;          // Word still in flight
  logic                      aux_sel_reg;   // Second controller owns output
  logic                      tdo_reg;       // Output bit
  logic                      tdo_oe_reg;    // Output enable
  logic                      bnd_drive_reg; // Boundary drives pins
  logic                      chains_live;   // Data chains may move
  logic                      dr_bit;        // Data chain output bit
  logic                      aux_ir;        // Instruction for second controller

  // Map codes we do not implement onto BYPASS
  always_comb begin
    case (ir_reg)
      `JTP_IR_EXTEST, `JTP_IR_INTEST, `JTP_IR_SAMPLE,
      `JTP_IR_USER, `JTP_IR_ABORT, `JTP_IR_DPACC,
      `JTP_IR_APACC, `JTP_IR_IDCODE: ir_eff = ir_reg;
      default: ir_eff = `JTP_IR_BYPASS; // [RULE11]
    endcase
  end

  // Instructions owned by the embedded second controller
  assign aux_ir = (ir_eff == `JTP_IR_ABORT) || (ir_eff == `JTP_IR_DPACC) ||
                  (ir_eff == `JTP_IR_APACC);

  // EXTEST and INTEST freeze every data chain
  assign chains_live = (ir_eff != `JTP_IR_EXTEST) && (ir_eff != `JTP_IR_INTEST) &&
                       !aux_ir; // [RULE12]

  // Next state of the standard graph
  always_comb begin
    case (state_reg)
      JTP_ST_RESET:  state_next = tms ? JTP_ST_RESET  : JTP_ST_IDLE;
      JTP_ST_IDLE:   state_next = tms ? JTP_ST_SEL_DR : JTP_ST_IDLE;
      JTP_ST_SEL_DR: state_next = tms ? JTP_ST_SEL_IR : JTP_ST_CAP_DR;
      JTP_ST_CAP_DR: state_next = tms ? JTP_ST_EX1_DR : JTP_ST_SH_DR;
      JTP_ST_SH_DR:  state_next = tms ? JTP_ST_EX1_DR : JTP_ST_SH_DR;
      JTP_ST_EX1_DR: state_next = tms ? JTP_ST_UPD_DR : JTP_ST_PA_DR;
      JTP_ST_PA_DR:  state_next = tms ? JTP_ST_EX2_DR : JTP_ST_PA_DR;
      JTP_ST_EX2_DR: state_next = tms ? JTP_ST_UPD_DR : JTP_ST_SH_DR;
      JTP_ST_UPD_DR: state_next = tms ? JTP_ST_SEL_DR : JTP_ST_IDLE;
      // Select-IR with high mode-select is the fifth step home
      JTP_ST_SEL_IR: state_next = tms ? JTP_ST_RESET  : JTP_ST_CAP_IR; // [RULE4]
      JTP_ST_CAP_IR: state_next = tms ? JTP_ST_EX1_IR : JTP_ST_SH_IR;
      JTP_ST_SH_IR:  state_next = tms ? JTP_ST_EX1_IR : JTP_ST_SH_IR;
      JTP_ST_EX1_IR: state_next = tms ? JTP_ST_UPD_IR : JTP_ST_PA_IR;
      JTP_ST_PA_IR:  state_next = tms ? JTP_ST_EX2_IR : JTP_ST_PA_IR;
      JTP_ST_EX2_IR: state_next = tms ? JTP_ST_UPD_IR : JTP_ST_SH_IR;
      JTP_ST_UPD_IR: state_next = tms ? JTP_ST_SEL_DR : JTP_ST_IDLE;
      default:       state_next = JTP_ST_RESET;
    endcase // [RULE19]
  end

  // State register; no edge means no change when the clock stops
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_reg <= JTP_ST_RESET; // [RULE2] [RULE5]
    end else begin
      state_reg <= state_next; // [RULE1] [RULE6]
    end
  end

  // Instruction chain: capture pattern, then shift in from tdi
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_shift_reg <= `JTP_IR_CAPT;
    end else if (state_reg == JTP_ST_CAP_IR) begin
      ir_shift_reg <= `JTP_IR_CAPT; // [RULE15]
    end else if (state_reg == JTP_ST_SH_IR) begin
      ir_shift_reg <= {tdi, ir_shift_reg[`JTP_IR_W-1:1]}; // [RULE7] [RULE17]
    end
  end

  // Held instruction; reset state always restores IDCODE
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_reg <= `JTP_IR_IDCODE;
    end else if (state_reg == JTP_ST_RESET) begin
      ir_reg <= `JTP_IR_IDCODE; // [RULE3]
    end else if (state_reg == JTP_ST_UPD_IR) begin
      ir_reg <= ir_shift_reg; // [RULE16]
    end
  end

  // Second-controller select follows the held instruction
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      aux_sel_reg <= 1'b0;
    end else begin
      aux_sel_reg <= aux_ir; // [RULE18]
    end
  end

  // Bypass chain, one bit, captures zero
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      byp_reg <= 1'b0;
    end else if (ir_eff == `JTP_IR_BYPASS) begin
      if (state_reg == JTP_ST_CAP_DR) begin
        byp_reg <= 1'b0; // [RULE13] [RULE15]
      end else if (state_reg == JTP_ST_SH_DR) begin
        byp_reg <= tdi; // [RULE7]
      end
    end
  end

  // Identity chain, captures the identity value
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_shift_reg <= '0;
    end else if (ir_eff == `JTP_IR_IDCODE) begin
      if (state_reg == JTP_ST_CAP_DR) begin
        id_shift_reg <= ID_VALUE; // [RULE15]
      end else if (state_reg == JTP_ST_SH_DR) begin
        id_shift_reg <= {tdi, id_shift_reg[`JTP_ID_W-1:1]}; // [RULE7]
      end
    end
  end

  // Pin sampler: three stages, value counts once the last two agree
  genvar gi;
  generate
    for (gi = 0; gi < `JTP_BND_W; gi++) begin : g_pin
      logic [2:0] sync_reg; // Stage 0 is read only by stage 1
      always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
          sync_reg <= 3'h0;
        end else begin
          sync_reg <= {sync_reg[1:0], bnd_in[gi]};
        end
      end
      // Settled copy ignores a level still ringing through
      always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
          bnd_smp_reg[gi] <= 1'b0;
        end else if (sync_reg[1] == sync_reg[2]) begin
          bnd_smp_reg[gi] <= sync_reg[2];
        end
      end
    end
  endgenerate

  // Boundary chain for SAMPLE/PRELOAD; EXTEST leaves it alone
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bnd_shift_reg <= `JTP_BND_RST;
      bnd_upd_reg   <= `JTP_BND_RST;
    end else if (chains_live && ir_eff == `JTP_IR_SAMPLE) begin // [RULE12] [RULE13]
      case (state_reg)
        JTP_ST_CAP_DR: bnd_shift_reg <= bnd_smp_reg; // [RULE15]
        JTP_ST_SH_DR:  bnd_shift_reg <= {tdi, bnd_shift_reg[`JTP_BND_W-1:1]};
        JTP_ST_UPD_DR: bnd_upd_reg   <= bnd_shift_reg; // [RULE16]
        default:       bnd_upd_reg   <= bnd_upd_reg;
      endcase
    end
  end

  // EXTEST puts the preloaded boundary value on the pins
  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bnd_drive_reg <= 1'b0;
    end else begin
      bnd_drive_reg <= (ir_eff == `JTP_IR_EXTEST); // [RULE12]
    end
  end

  // Ack toggle from system side; power-on reset only, so a test reset keeps the toggles paired
  logic [2:0] ack_sync_reg; // Stage 0 is read only by stage 1
  logic       ack_tgl_reg;  // System-side ack toggle
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      ack_sync_reg <= 3'h0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
    end
  end

  // Settled ack value
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      ack_seen_reg <= 1'b0;
    end else if (ack_sync_reg[1] == ack_sync_reg[2]) begin
      ack_seen_reg <= ack_sync_reg[2];
    end
  end

  // A word is in flight until its ack returns
  assign busy = req_tgl_reg != ack_seen_reg;

  // User chain: captures busy flag, update hands the word over; test reset must not split a toggle pair
  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      usr_shift_reg <= `JTP_USR_RST;
      usr_word_reg  <= `JTP_USR_RST;
      req_tgl_reg   <= 1'b0;
    end else if (ir_eff == `JTP_IR_USER) begin // [RULE13]
      case (state_reg)
        JTP_ST_CAP_DR: usr_shift_reg <= {{(`JTP_USR_W-1){1'b0}}, busy}; // [RULE15]
        JTP_ST_SH_DR:  usr_shift_reg <= {tdi, usr_shift_reg[`JTP_USR_W-1:1]};
        JTP_ST_UPD_DR: begin
          // Held word must stay still while in flight, so drop a new one
          if (!busy) begin
            usr_word_reg <= usr_shift_reg; // [RULE16]
            req_tgl_reg  <= ~req_tgl_reg;
          end
        end
        default:       req_tgl_reg <= req_tgl_reg;
      endcase
    end
  end

  // Bit at the output end of the selected data chain
  always_comb begin
    case (ir_eff)
      `JTP_IR_IDCODE: dr_bit = id_shift_reg[0];
      `JTP_IR_SAMPLE: dr_bit = bnd_shift_reg[0];
      `JTP_IR_USER:   dr_bit = usr_shift_reg[0];
      default:        dr_bit = byp_reg;
    endcase
  end

  // Output launched on the falling edge for the next rising sample
  always_ff @(negedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0; // [RULE10]
    end else if (state_reg == JTP_ST_SH_IR) begin
      tdo_reg    <= ir_shift_reg[0]; // [RULE9]
      tdo_oe_reg <= 1'b1;
    end else if (state_reg == JTP_ST_SH_DR && aux_sel_reg) begin
      tdo_reg    <= aux_tdo; // [RULE18]
      tdo_oe_reg <= 1'b1;
    end else if (state_reg == JTP_ST_SH_DR && chains_live) begin
      tdo_reg    <= dr_bit; // [RULE9] [RULE14]
      tdo_oe_reg <= 1'b1;
    end else begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0; // [RULE10]
    end
  end

  // System side: request toggle settles through three stages
  logic [2:0] req_sync_reg; // Stage 0 is read only by stage 1
  logic       pend;         // New word waiting for buffer room
  logic       buf_ready;    // Buffer can take a word
  jtp_word_t  xfer_word;    // Word carried over
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_sync_reg <= 3'h0;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
    end
  end

  // Pending when settled request differs from our ack
  assign pend           = (req_sync_reg[1] == req_sync_reg[2]) && (req_sync_reg[2] != ack_tgl_reg);
  assign xfer_word.data = usr_word_reg; // Stable while pending

  // Ack only once the buffer took the word; a full buffer stalls here
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_tgl_reg <= 1'b0;
    end else if (pend && buf_ready) begin
      ack_tgl_reg <= ~ack_tgl_reg;
    end
  end

  // Two-entry buffer toward the receiver
  jtp_buf2 u_buf (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .in_valid  (pend),
    .in_ready  (buf_ready),
    .in_word   (xfer_word),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_word  (word_data)
  );

  // Pin-facing outputs straight from flops
  assign tdo       = tdo_reg;
  assign tdo_oe    = tdo_oe_reg;
  assign aux_sel   = aux_sel_reg;
  assign bnd_out   = bnd_upd_reg;
  assign bnd_drive = bnd_drive_reg;
endmodule : jtp_tap

// ---- rtl/jtp_consts.svh ----
`ifndef JTP_CONSTS_SVH
`define JTP_CONSTS_SVH

// Chain widths
`define JTP_IR_W      4
`define JTP_ID_W      32
`define JTP_BND_W     8
`define JTP_USR_W     8

// Instruction codes
`define JTP_IR_EXTEST 4'h0
`define JTP_IR_INTEST 4'h1
`define JTP_IR_SAMPLE 4'h2
`define JTP_IR_USER   4'h4
`define JTP_IR_ABORT  4'h8
`define JTP_IR_DPACC  4'ha
`define JTP_IR_APACC  4'hb
`define JTP_IR_IDCODE 4'he
`define JTP_IR_BYPASS 4'hf

// Capture values and reset values
`define JTP_IR_CAPT   4'h1
`define JTP_ID_RST    32'h0000_0001
`define JTP_USR_RST   8'h00
`define JTP_BND_RST   8'h00

`endif

// ---- rtl/jtp_pkg.sv ----
package jtp_pkg;
  `include "jtp_consts.svh"

  // Sixteen TAP controller states
  typedef enum {
    JTP_ST_RESET, JTP_ST_IDLE,
    JTP_ST_SEL_DR, JTP_ST_CAP_DR, JTP_ST_SH_DR, JTP_ST_EX1_DR,
    JTP_ST_PA_DR, JTP_ST_EX2_DR, JTP_ST_UPD_DR,
    JTP_ST_SEL_IR, JTP_ST_CAP_IR, JTP_ST_SH_IR, JTP_ST_EX1_IR,
    JTP_ST_PA_IR, JTP_ST_EX2_IR, JTP_ST_UPD_IR
  } jtp_state_t;

  // Word handed from the test link to the system side
  typedef struct packed {
    logic [`JTP_USR_W-1:0] data;
  } jtp_word_t;
endpackage : jtp_pkg

// ---- rtl/jtp_buf2.sv ----
`timescale 1ns/1ns
module jtp_buf2
  import jtp_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      nrst,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire jtp_word_t in_word,
  output logic           out_valid,
  input  wire logic      out_ready,
  output jtp_word_t      out_word
);
  jtp_word_t head_reg;   // Oldest word, shown at output
  jtp_word_t tail_reg;   // Second word
  logic      head_v_reg; // Head holds a word
  logic      tail_v_reg; // Tail holds a word
  logic      push;       // Word enters
  logic      pop;        // Word leaves

  // Full only when both slots hold words
  assign in_ready  = !tail_v_reg;
  assign push      = in_valid && !tail_v_reg;
  assign pop       = head_v_reg && out_ready;
  assign out_valid = head_v_reg;
  assign out_word  = head_reg;

  // Slot movement; the tail always drains into the head
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      head_reg   <= '0;
      tail_reg   <= '0;
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
    end else if (pop) begin
      if (tail_v_reg) begin
        head_reg   <= tail_reg;
        head_v_reg <= 1'b1;
        tail_v_reg <= push;
        if (push) begin
          tail_reg <= in_word;
        end
      end else begin
        head_v_reg <= push;
        if (push) begin
          head_reg <= in_word;
        end
      end
    end else if (push) begin
      if (!head_v_reg) begin
        head_reg   <= in_word;
        head_v_reg <= 1'b1;
      end else begin
        tail_reg   <= in_word;
        tail_v_reg <= 1'b1;
      end
    end
  end
endmodule : jtp_buf2

// ---- dv/jtp_tap_monitor.sv ----
`timescale 1ns/1ns
`include "jtp_consts.svh"
module jtp_tap_mon
  import jtp_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire logic                  tck,
  input wire logic                  trst_n,
  input wire logic                  tms,
  input wire logic                  tdi,
  input wire logic                  tdo,
  input wire logic                  tdo_oe,
  input wire logic                  aux_tdo,
  input wire logic                  aux_sel,
  input wire logic [`JTP_BND_W-1:0] bnd_in,
  input wire logic [`JTP_BND_W-1:0] bnd_out,
  input wire logic                  bnd_drive,
  input wire logic                  word_valid,
  input wire jtp_word_t             word_data,
  input wire logic                  word_ready
);
  // Output parked low whenever not shifting
  property p_tdo_idle;
    @(posedge sys_clk) disable iff (!nrst || !trst_n) !tdo_oe |-> !tdo;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle) else $error("tdo active while idle");
  // Output pins move only while the test clock is low
  property p_tdo_fall;
    @(posedge sys_clk) disable iff (!nrst || !trst_n) ($changed(tdo) || $changed(tdo_oe)) |-> !tck;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with clock high");
  // Test reset clears the link-side outputs at once
  property p_trst;
    @(posedge sys_clk) disable iff (!nrst) !trst_n |-> !tdo_oe && !tdo && !aux_sel && !bnd_drive && bnd_out == 8'h00;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset not applied");
  // Power-on reset clears both sides; no disable, it is the reset itself
  property p_por;
    @(posedge sys_clk) !nrst |-> !tdo_oe && !aux_sel && !bnd_drive && !word_valid;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset not applied");
  // Stopped test clock freezes tdo, bnd_out, aux_sel and bnd_drive
  property p_hold;
    @(posedge sys_clk) disable iff (!nrst || !trst_n)
      tck == $past(tck) |-> $stable(tdo) && $stable(bnd_out) && $stable(aux_sel) && $stable(bnd_drive);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with clock stopped");
  // Long run of high mode-select lands in reset with the default instruction
  property p_five;
    @(posedge tck) disable iff (!nrst || !trst_n) tms [*7] |=> !tdo_oe && !aux_sel && !bnd_drive;
  endproperty
  a_five: assert property (p_five) else $error("mode-select reset missed");
  // Shift entered only after a low mode-select edge
  property p_oe_rise;
    @(negedge tck) disable iff (!nrst || !trst_n) $rose(tdo_oe) |-> !$past(tms);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("shift entered wrongly");
  // Boundary update register frozen while EXTEST holds
  property p_bnd;
    @(posedge tck) disable iff (!nrst || !trst_n) bnd_drive && $past(bnd_drive) |-> $stable(bnd_out);
  endproperty
  a_bnd: assert property (p_bnd) else $error("boundary moved in EXTEST");
  // Stalled word holds until taken
  property p_buf;
    @(posedge sys_clk) disable iff (!nrst) word_valid && !word_ready |=> word_valid && $stable(word_data);
  endproperty
  a_buf: assert property (p_buf) else $error("word lost under stall");
  c_shift: cover property (@(negedge tck) $rose(tdo_oe));
  c_take: cover property (@(posedge sys_clk) word_valid && word_ready);
  c_drive: cover property (@(posedge tck) bnd_drive);
  c_aux: cover property (@(posedge tck) aux_sel && tdo_oe);
endmodule : jtp_tap_mon

bind jtp_tap jtp_tap_mon i_mon (.sys_clk(sys_clk), .nrst(nrst), .tck(tck), .trst_n(trst_n), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .aux_tdo(aux_tdo), .aux_sel(aux_sel), .bnd_in(bnd_in),
  .bnd_out(bnd_out), .bnd_drive(bnd_drive), .word_valid(word_valid), .word_data(word_data),
  .word_ready(word_ready));

// ---- dv/jtp_prb.sv ----
`timescale 1ns/1ns
module jtp_prb (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      aux_tdo,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // Clock parked low between frames, lines at pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    aux_tdo = 1'b0;
  end
  // One test clock; inputs move at the falling edge, output read at rise
  task automatic clk(input logic m, input logic d, output logic [1:0] s);
    tms = m;
    tdi = d;
    #62 tck = 1'b1;
    s = {tdo_oe, tdo_oe ? tdo : 1'b1}; // Undriven line reads as its pull-up
    #63 tck = 1'b0;
  endtask : clk
  // From idle: select branch, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe);
    logic [1:0] s;
    int         i;
    clk(1'b1, 1'b1, s);
    if (ir) clk(1'b1, 1'b1, s);
    clk(1'b0, 1'b1, s);
    clk(1'b0, 1'b1, s);
    dout = '0;
    oe = 1'b1;
    for (i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], s);
      dout[i] = s[0];
      oe = oe & (s[1] === 1'b1);
    end
    clk(1'b1, 1'b1, s);
    clk(1'b0, 1'b1, s);
  endtask : scan
  // Reset by mode-select alone, then park in idle
  task automatic tlr;
    logic [1:0] s;
    repeat (7) clk(1'b1, 1'b1, s);
    clk(1'b0, 1'b1, s);
  endtask : tlr
endmodule : jtp_prb

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`include "jtp_consts.svh"
module tb_top
  import jtp_pkg::*;
;
  localparam logic [31:0] ID_TB = 32'h0000_5a31; // Arbitrary identity value
  logic        sys_clk, nrst, trst_n, word_ready;
  logic        tck, tms, tdi, tdo, tdo_oe, aux_tdo, aux_sel, bnd_drive, word_valid;
  logic [7:0]  bnd_in, bnd_out;
  jtp_word_t   word_data;
  logic [31:0] dout;
  logic        oe;
  logic [1:0]  s;
  int          fails, tests_run;

  jtp_tap #(.ID_VALUE(ID_TB)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .aux_tdo(aux_tdo), .aux_sel(aux_sel),
    .bnd_in(bnd_in), .bnd_out(bnd_out), .bnd_drive(bnd_drive), .word_valid(word_valid),
    .word_data(word_data), .word_ready(word_ready));
  jtp_prb i_prb (.tck(tck), .tms(tms), .tdi(tdi), .aux_tdo(aux_tdo), .tdo(tdo), .tdo_oe(tdo_oe));

  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic results;
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Load an instruction, then one idle clock so held outputs settle
  task automatic ld(input logic [3:0] c);
    i_prb.scan(1'b1, 4, {28'h0, c}, dout, oe);
    i_prb.clk(1'b0, 1'b1, s);
  endtask : ld
  // Default instruction after power-on; instruction capture pattern
  task automatic t_idcode;
    i_prb.scan(1'b0, 32, 32'h0, dout, oe);
    chk(dout, ID_TB, "idcode");
    chk(oe, 1'b1, "oe in shift");
    i_prb.scan(1'b1, 4, 32'hf, dout, oe);
    chk({oe, dout[3:0]}, {1'b1, `JTP_IR_CAPT}, "ir capture");
  endtask : t_idcode
  // Unimplemented codes and BYPASS give a one-bit path capturing 0
  task automatic t_bypass;
    logic [3:0] codes [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd, `JTP_IR_BYPASS};
    foreach (codes[k]) begin
      ld(codes[k]);
      i_prb.scan(1'b0, 4, 32'hb, dout, oe);
      chk({oe, dout[3:0]}, 5'h16, "bypass path");
    end
  endtask : t_bypass
  // Test reset, power-on reset and mode-select reset mid-shift
  task automatic t_resets;
    for (int k = 0; k < 3; k++) begin
      ld(`JTP_IR_BYPASS);
      if (k == 2) begin
        i_prb.clk(1'b1, 1'b0, s);
        repeat (2) i_prb.clk(1'b0, 1'b0, s);
        i_prb.tlr();
      end else begin
        @(posedge sys_clk) #1;
        if (k == 0) trst_n = 1'b0;
        else nrst = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 trst_n = 1'b1;
        nrst = 1'b1;
        i_prb.clk(1'b0, 1'b1, s);
      end
      i_prb.scan(1'b0, 32, 32'h0, dout, oe);
      chk(dout, ID_TB, "idcode after reset");
    end
  endtask : t_resets
  // Sample and update boundary, then EXTEST and INTEST leave chains alone
  task automatic t_bnd;
    @(posedge sys_clk) #1 bnd_in = 8'ha5;
    ld(`JTP_IR_SAMPLE);
    i_prb.scan(1'b0, 8, 32'h3c, dout, oe);
    chk({oe, dout[7:0]}, 9'h1a5, "sample capture");
    chk(bnd_out, 8'h3c, "boundary update");
    @(posedge sys_clk) #1 bnd_in = 8'h11;
    for (int j = 0; j < 2; j++) begin
      ld(j[3:0]);
      chk(bnd_drive, j == 0, "extest drive");
      i_prb.scan(1'b0, 8, 32'hff, dout, oe);
      chk({oe, dout[7:0], bnd_out}, {9'h0ff, 8'h3c}, "frozen chains");
    end
    ld(`JTP_IR_SAMPLE);
    i_prb.scan(1'b0, 8, 32'h3c, dout, oe);
    chk(dout[7:0], 8'h11, "sample again");
  endtask : t_bnd
  // Second controller owns the output for its instructions
  task automatic t_aux;
    logic [3:0] codes [3] = '{`JTP_IR_ABORT, `JTP_IR_DPACC, `JTP_IR_APACC};
    foreach (codes[k]) begin
      ld(codes[k]);
      chk(aux_sel, 1'b1, "aux select");
      i_prb.aux_tdo = codes[k][0];
      i_prb.scan(1'b0, 8, 32'h0, dout, oe);
      chk({oe, dout[7:0]}, {1'b1, {8{codes[k][0]}}}, "aux path");
    end
    i_prb.tlr();
    chk(aux_sel, 1'b0, "aux after mode-select reset");
    ld(`JTP_IR_IDCODE);
    chk(aux_sel, 1'b0, "aux released");
  endtask : t_aux
  // Fill word buffer under stall until busy shows, then drain in order
  task automatic t_user;
    logic [7:0] w [4] = '{8'h5e, 8'h81, 8'h42, 8'h99};
    int         n;
    ld(`JTP_IR_USER);
    foreach (w[k]) begin
      i_prb.scan(1'b0, 8, {24'h0, w[k]}, dout, oe);
      chk({oe, dout[0]}, {1'b1, k == 3}, "busy flag");
      repeat (4) i_prb.clk(1'b0, 1'b1, s);
    end
    for (int j = 0; j < 3; j++) begin
      n = 0;
      @(posedge sys_clk) #1;
      while (word_valid !== 1'b1 && n < 200) begin
        @(posedge sys_clk) #1;
        n++;
      end
      chk({word_valid, word_data.data}, {1'b1, w[j]}, "word out");
      word_ready = 1'b1;
      @(posedge sys_clk) #1 word_ready = 1'b0;
      @(posedge sys_clk) #1;
    end
    repeat (50) @(posedge sys_clk);
    chk(word_valid, 1'b0, "dropped word");
  endtask : t_user
  // Watchdog
  initial begin
    #300000;
    fails++;
    results();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    trst_n = 1'b1;
    word_ready = 1'b0;
    bnd_in = 8'h00;
    fails = 0;
    tests_run = 0;
    fork
      #20 i_prb.clk(1'b1, 1'b1, s);
      repeat (20) @(posedge sys_clk);
    join
    #1 nrst = 1'b1;
    i_prb.tlr();
    t_idcode();
    t_bypass();
    t_resets();
    t_bnd();
    t_aux();
    t_user();
    results();
  end
endmodule : tb_top
